// *** rtl/rwc_top.v ***
// rwc_top.v: watchdog timer and real-time clock control, with the event
// status register, its mask and one interrupt line, on an AHB-Lite slave.
// assumes a single ref_clk domain; the oscillator arrives as a
// synchronous one-cycle tick, and the system reset controller acts on
// wdog_reset_req.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "rwc_defines.vh"

// Notes on behaviour
// - watchdog count rises once a second when enabled
// - count reaching binary 10 triggers timeout action
// - any write restarts count at zero
// - count advances on the one-second tick only
// - watchdog flag set on interrupt, write-one clears
// - select bit: 0 reset, 1 interrupt; reset 0
// - enable bit turns watchdog on; reset 1
// - run bit starts or stops the clock; reset 1
// - frequency bit picks the prescaler divide ratio
// - status bits set on event, stay set
// - write ones to clear; request withdrawn too
// - status works without bus activity
// - one-second flag set on each seconds step
module rwc_top #(
  parameter [`RWC_PRE_W-1:0] DIV_32K = `RWC_TERM_32K, // ticks-1, 32.768k
  parameter [`RWC_PRE_W-1:0] DIV_38K = `RWC_TERM_38K  // ticks-1, 38.4k
) (
  input  wire        ref_clk,        // 100 MHz system clock
  input  wire        rst,            // async reset, active high
  input  wire        osc_tick,       // reference oscillator tick
  input  wire        hsel,           // slave select
  input  wire [31:0] haddr,          // byte address
  input  wire [1:0]  htrans,         // transfer type
  input  wire        hwrite,         // write when high
  input  wire [2:0]  hsize,          // transfer size, word only
  input  wire [31:0] hwdata,         // write data
  input  wire        hready,         // bus ready in
  output reg  [31:0] hrdata,         // read data
  output reg         hreadyout,      // slave ready out
  output reg         hresp,          // always OKAY
  output reg         rtc_irq,        // level interrupt, unmasked status
  output reg         wdog_irq,       // watchdog interrupt request
  output reg         wdog_reset_req  // one-cycle system reset request
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg  [1:0]            wdog_count;
  reg                   wdog_irq_flag;
  reg                   timeout_action_select;
  reg                   wdog_enable;
  reg                   rtc_run;
  reg                   osc_freq_select;
  reg  [`RWC_ST_W-1:0]  rtc_event_status;
  reg  [`RWC_ST_W-1:0]  rtc_event_mask;

  // bus phase state
  reg                   wr_pend;
  reg                   rd_pend;
  reg  [`RWC_ADDR_W-1:0] dp_addr;

  // next values
  reg  [1:0]            next_wdog_count;
  reg                   next_wdog_irq_flag;
  reg                   next_wdog_reset_req;
  reg  [`RWC_ST_W-1:0]  next_rtc_event_status;
  reg  [31:0]           next_hrdata;

  wire                  sec_tick;
  wire                  addr_ok;
  wire                  wr_wdog;
  wire                  wr_ctrl;
  wire                  wr_status;
  wire                  wr_mask;
  wire                  timeout;
  wire [`RWC_ST_W-1:0]  st_set;
  wire [`RWC_ST_W-1:0]  st_clr;

  // ---------------------------------------------------------------
  // one-second tick from the oscillator
  // ---------------------------------------------------------------
  // stopping the clock also starves the watchdog of ticks, so a halted
  // clock can never cause a spurious timeout
  rwc_prescaler #(
    .DIV_32K (DIV_32K),
    .DIV_38K (DIV_38K)
  ) u_pre (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .osc_tick (osc_tick),
    .run      (rtc_run),
    .freq_sel (osc_freq_select),
    .sec_tick (sec_tick)
  );

  // ---------------------------------------------------------------
  // AHB-Lite address phase
  // ---------------------------------------------------------------
  // only NONSEQ transfers are acted on, hsize is not checked; others get OKAY and no
  // effect, which is the safe answer for an unsupported access
  assign addr_ok = hsel && hready && (htrans == `RWC_HTRANS_NONSEQ);

  // reads take one wait state so that a write in the previous data
  // phase is already visible when the read data is captured
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      dp_addr   <= {`RWC_ADDR_W{1'b0}};
      hreadyout <= 1'b1;
      hresp     <= `RWC_HRESP_OKAY;
    end else begin
      hresp <= `RWC_HRESP_OKAY;
      if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end else if (addr_ok) begin
        wr_pend   <= hwrite;
        rd_pend   <= ~hwrite;
        hreadyout <= hwrite;
        dp_addr   <= haddr[`RWC_ADDR_W-1:0];
      end else begin
        wr_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // data phase write strobes, one per register
  assign wr_wdog   = wr_pend && (dp_addr == `RWC_OFS_WDOG);
  assign wr_ctrl   = wr_pend && (dp_addr == `RWC_OFS_CTRL);
  assign wr_status = wr_pend && (dp_addr == `RWC_OFS_STATUS);
  assign wr_mask   = wr_pend && (dp_addr == `RWC_OFS_MASK);

  // ---------------------------------------------------------------
  // watchdog counter
  // ---------------------------------------------------------------
  // timeout is the step from 01 to 10; the count then parks at 10 so the
  // action fires exactly once until software restarts it
  assign timeout = wdog_enable && sec_tick &&
                   (wdog_count == `RWC_WD_CNT_ONE);

  always @* begin
    next_wdog_count = wdog_count;
    if (wr_wdog) begin
      next_wdog_count = `RWC_WD_CNT_ZERO;
    end else if (wdog_enable && sec_tick &&
                 (wdog_count != `RWC_WD_CNT_TIMEOUT)) begin
      next_wdog_count = wdog_count + `RWC_WD_CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // watchdog flag and timeout action
  // ---------------------------------------------------------------
  // a timeout with interrupt selected in the same cycle as a write-one clear keeps the flag set
  always @* begin
    next_wdog_irq_flag  = wdog_irq_flag;
    next_wdog_reset_req = 1'b0;
    if (wr_wdog && hwdata[`RWC_WD_FLAG_BIT]) begin
      next_wdog_irq_flag = 1'b0;
    end
    if (timeout) begin
      if (timeout_action_select == `RWC_SEL_RESET) begin
        next_wdog_reset_req = 1'b1;
      end else begin
        next_wdog_irq_flag = 1'b1;
      end
    end
  end

  // watchdog control register and its outputs
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdog_count            <= `RWC_WD_CNT_ZERO;
      wdog_irq_flag         <= 1'b0;
      timeout_action_select <= `RWC_WD_SEL_RST;
      wdog_enable           <= `RWC_WD_EN_RST;
      wdog_reset_req        <= 1'b0;
      wdog_irq              <= 1'b0;
    end else begin
      wdog_count     <= next_wdog_count;
      wdog_irq_flag  <= next_wdog_irq_flag;
      wdog_reset_req <= next_wdog_reset_req;
      // request tracks the flag, so clearing it withdraws the request
      wdog_irq       <= next_wdog_irq_flag;
      if (wr_wdog) begin
        timeout_action_select <= hwdata[`RWC_WD_SEL_BIT];
        wdog_enable           <= hwdata[`RWC_WD_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // rtc control register
  // ---------------------------------------------------------------
  // software must match the frequency bit to the fitted crystal; a
  // wrong setting only skews the second, it cannot lock the divider
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtc_run         <= `RWC_CTRL_RUN_RST;
      osc_freq_select <= `RWC_CTRL_FREQ_RST;
    end else if (wr_ctrl) begin
      rtc_run         <= hwdata[`RWC_CTRL_RUN_BIT];
      osc_freq_select <= hwdata[`RWC_CTRL_FREQ_BIT];
    end
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt line
  // ---------------------------------------------------------------
  // events: one-second step and the watchdog interrupt; the second is
  // flagged even when masked so software can poll it for fine timing
  assign st_set = ({{(`RWC_ST_W-1){1'b0}}, sec_tick}
                   << `RWC_ST_SEC_BIT)
                | ({{(`RWC_ST_W-1){1'b0}}, timeout &
                    timeout_action_select}
                   << `RWC_ST_WDOG_BIT);
  assign st_clr = wr_status ? hwdata[`RWC_ST_W-1:0]
                            : {`RWC_ST_W{1'b0}};

  // set wins over a clear in the same cycle; needs no bus transfer, only
  // ref_clk and the oscillator tick, so events post while the core sleeps
  always @* begin
    next_rtc_event_status = (rtc_event_status & ~st_clr) | st_set;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtc_event_status <= `RWC_ST_RST;
      rtc_event_mask   <= `RWC_ST_RST;
      rtc_irq          <= 1'b0;
    end else begin
      rtc_event_status <= next_rtc_event_status;
      if (wr_mask) begin
        rtc_event_mask <= hwdata[`RWC_ST_W-1:0];
      end
      // level output, dropped once every unmasked bit is cleared
      rtc_irq <= |(next_rtc_event_status &
                   (wr_mask ? hwdata[`RWC_ST_W-1:0]
                            : rtc_event_mask));
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // reserved bits and unmapped offsets read as zero
  always @* begin
    next_hrdata = `RWC_WORD_ZERO;
    case (dp_addr)
      `RWC_OFS_WDOG: begin
        next_hrdata[`RWC_WD_CNT_HI:`RWC_WD_CNT_LO] = wdog_count;
        next_hrdata[`RWC_WD_FLAG_BIT] = wdog_irq_flag;
        next_hrdata[`RWC_WD_SEL_BIT]  = timeout_action_select;
        next_hrdata[`RWC_WD_EN_BIT]   = wdog_enable;
      end
      `RWC_OFS_CTRL: begin
        next_hrdata[`RWC_CTRL_RUN_BIT]  = rtc_run;
        next_hrdata[`RWC_CTRL_FREQ_BIT] = osc_freq_select;
      end
      `RWC_OFS_STATUS: begin
        next_hrdata[`RWC_ST_W-1:0] = rtc_event_status;
      end
      `RWC_OFS_MASK: begin
        next_hrdata[`RWC_ST_W-1:0] = rtc_event_mask;
      end
      default: begin
        next_hrdata = `RWC_WORD_ZERO;
      end
    endcase
  end

  // captured in the wait cycle, held until the next read
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= `RWC_WORD_ZERO;
    end else if (rd_pend) begin
      hrdata <= next_hrdata;
    end
  end

endmodule // rwc_top

// *** rtl/rwc_defines.vh ***
// rwc_defines.vh: register map, field positions and reset values of the
// watchdog and real-time clock control block.
// assumes a 32-bit AHB-Lite bus, one word per register.
`ifndef RWC_DEFINES_VH
`define RWC_DEFINES_VH

// register byte addresses (low address bits only)
`define RWC_ADDR_W          4
`define RWC_OFS_WDOG        4'h0
`define RWC_OFS_CTRL        4'h4
`define RWC_OFS_STATUS      4'h8
`define RWC_OFS_MASK        4'hC

// watchdog_control fields
`define RWC_WD_EN_BIT       0
`define RWC_WD_SEL_BIT      1
`define RWC_WD_FLAG_BIT     7
`define RWC_WD_CNT_LO       8
`define RWC_WD_CNT_HI       9
`define RWC_WD_CNT_ZERO     2'h0
`define RWC_WD_CNT_ONE      2'h1
`define RWC_WD_CNT_TIMEOUT  2'h2
`define RWC_WD_EN_RST       1'h1
`define RWC_WD_SEL_RST      1'h0
`define RWC_SEL_RESET       1'h0

// rtc_control fields
`define RWC_CTRL_FREQ_BIT   5
`define RWC_CTRL_RUN_BIT    7
`define RWC_CTRL_RUN_RST    1'h1
`define RWC_CTRL_FREQ_RST   1'h0

// rtc_event_status / mask fields
`define RWC_ST_W            8
`define RWC_ST_WDOG_BIT     7
`define RWC_ST_SEC_BIT      4
`define RWC_ST_RST          8'h00

// oscillator ticks per second
`define RWC_DIV_32K         32768
`define RWC_DIV_38K         38400
`define RWC_PRE_W           16
// terminal counts, ticks per second minus one, at prescaler width
`define RWC_TERM_32K        16'h7FFF
`define RWC_TERM_38K        16'h95FF

// AHB-Lite encodings
`define RWC_HTRANS_NONSEQ   2'h2
`define RWC_HRESP_OKAY      1'h0
`define RWC_WORD_ZERO       32'h00000000

`endif

// *** rtl/rwc_prescaler.v ***
// rwc_prescaler.v: divides the reference oscillator tick down to a
// one-second enable pulse.
// assumes osc_tick is a one-cycle pulse per oscillator period, already
// synchronous to ref_clk.
`timescale 1ns/100ps
`include "rwc_defines.vh"

module rwc_prescaler #(
  parameter [`RWC_PRE_W-1:0] DIV_32K = `RWC_TERM_32K, // terminal, 32.768k
  parameter [`RWC_PRE_W-1:0] DIV_38K = `RWC_TERM_38K  // terminal, 38.4k
) (
  input  wire ref_clk,   // system clock
  input  wire rst,       // async reset, active high
  input  wire osc_tick,  // one pulse per oscillator period
  input  wire run,       // prescaler runs while high
  input  wire freq_sel,  // 0: 32.768 kHz, 1: 38.4 kHz
  output reg  sec_tick   // one-cycle pulse once a second
);

  reg  [`RWC_PRE_W-1:0] count;
  wire [`RWC_PRE_W-1:0] terminal;

  // divide ratio follows the fitted oscillator
  assign terminal = freq_sel ? DIV_38K : DIV_32K;

  // a stopped clock keeps its phase so a restart resumes mid-second;
  // >= guards against a ratio switch landing above the new terminal
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count    <= {`RWC_PRE_W{1'b0}};
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (run && osc_tick) begin
        if (count >= terminal) begin
          count    <= {`RWC_PRE_W{1'b0}};
          sec_tick <= 1'b1;
        end else begin
          count <= count + {{(`RWC_PRE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // rwc_prescaler

// *** tb/rwc_top_properties.sv ***
// rwc_top_properties.sv: port assertions for the watchdog/clock block.
// assumes hready is fed back from hreadyout and one ref_clk domain.
`timescale 1ns/100ps
`include "rwc_defines.vh"

module rwc_props #(
  parameter [`RWC_PRE_W-1:0] DIV_32K = `RWC_TERM_32K, // shorter second
  parameter [`RWC_PRE_W-1:0] DIV_38K = `RWC_TERM_38K  // longer second
) (
  input wire        ref_clk,        // clock
  input wire        rst,            // async reset
  input wire        osc_tick,       // oscillator tick
  input wire        hsel,           // select
  input wire [31:0] haddr,          // address
  input wire [1:0]  htrans,         // transfer type
  input wire        hwrite,         // write
  input wire [2:0]  hsize,          // size
  input wire [31:0] hwdata,         // write data
  input wire        hready,         // bus ready
  input wire [31:0] hrdata,         // read data
  input wire        hreadyout,      // slave ready
  input wire        hresp,          // response
  input wire        rtc_irq,        // status interrupt
  input wire        wdog_irq,       // watchdog interrupt
  input wire        wdog_reset_req  // reset request
);
  reg        wr_dp;   // write data phase
  reg [3:0]  wr_ofs;  // offset of that write
  reg        sel_q;   // last select bit written
  reg        en_q;    // last enable bit written
  reg [17:0] tk;      // osc ticks since the last restart
  wire       take  = hsel & hready & (htrans == `RWC_HTRANS_NONSEQ);
  wire       wd_wr = wr_dp & (wr_ofs == `RWC_OFS_WDOG);

  // shadow of the watchdog settings; tick count saturates, never wraps
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_dp  <= 1'b0;
      wr_ofs <= 4'h0;
      sel_q  <= 1'b0;
      en_q   <= 1'b1;
      tk     <= 18'h00000;
    end else begin
      wr_dp  <= take & hwrite;
      wr_ofs <= haddr[3:0];
      if (wd_wr) begin
        sel_q <= hwdata[1];
        en_q  <= hwdata[0];
        tk    <= 18'h00000;
      end else if (osc_tick && !(&tk)) begin
        tk <= tk + 18'h00001;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_req_pulse; wdog_reset_req |=> !wdog_reset_req; endproperty
  property p_req_sel; wdog_reset_req |-> !sel_q; endproperty
  property p_irq_sel; $rose(wdog_irq) |-> sel_q; endproperty
  property p_disabled;
    !en_q |-> !wdog_reset_req && !$rose(wdog_irq);
  endproperty
  // a restart needs at least one whole second of ticks before a timeout
  property p_restart;
    wdog_reset_req || $rose(wdog_irq) |-> tk > {2'h0, DIV_32K};
  endproperty
  property p_irq_hold; wdog_irq && !wr_dp |=> wdog_irq; endproperty
  property p_irq_tick; $rose(wdog_irq) |-> $past(osc_tick, 2); endproperty
  property p_req_tick;
    $rose(wdog_reset_req) |-> $past(osc_tick, 2);
  endproperty
  // the clearing write's data phase ends one edge before the drop is seen
  property p_rtc_clear; $fell(rtc_irq) |-> $past(wr_dp); endproperty
  property p_read_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty

  a_req_pulse: assert property (p_req_pulse)
    else $error("reset request wider than one cycle");
  a_req_sel: assert property (p_req_sel)
    else $error("reset request with interrupt selected");
  a_irq_sel: assert property (p_irq_sel)
    else $error("watchdog interrupt with reset selected");
  a_disabled: assert property (p_disabled)
    else $error("timeout while watchdog disabled");
  a_restart: assert property (p_restart)
    else $error("timeout too soon after restart");
  a_irq_hold: assert property (p_irq_hold)
    else $error("watchdog interrupt dropped without a write");
  a_irq_tick: assert property (p_irq_tick)
    else $error("watchdog interrupt not tied to a tick");
  a_req_tick: assert property (p_req_tick)
    else $error("reset request not tied to a tick");
  a_rtc_clear: assert property (p_rtc_clear)
    else $error("status interrupt dropped without a write");
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state missing");

  c_req: cover property (wdog_reset_req);
  c_irq: cover property ($rose(wdog_irq));
  c_clr: cover property ($fell(rtc_irq));
endmodule // rwc_props

bind rwc_top rwc_props #(.DIV_32K(DIV_32K), .DIV_38K(DIV_38K)) i_props (
  .ref_clk(ref_clk), .rst(rst), .osc_tick(osc_tick), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rtc_irq(rtc_irq),
  .wdog_irq(wdog_irq), .wdog_reset_req(wdog_reset_req));

// *** tb/tb_rwc_top.sv ***
// tb_rwc_top.sv: self-checking bench for the watchdog/clock block.
// assumes the block is the only AHB-Lite slave; hready is its hreadyout.
`timescale 1ns/100ps

module tb_rwc_top;
  logic        ref_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        osc_tick = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h00000000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h00000000;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, rtc_irq, wdog_irq, wdog_reset_req;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_req = 0;
  int          t1, t2;
  logic [31:0] q;

  // short seconds: 8 ticks at 32.768k, 10 at 38.4k
  rwc_top #(.DIV_32K(16'h0007), .DIV_38K(16'h0009)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .osc_tick(osc_tick), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rtc_irq(rtc_irq),
    .wdog_irq(wdog_irq), .wdog_reset_req(wdog_reset_req));

  always #5 ref_clk = ~ref_clk;

  // oscillator tick every other cycle, cycle count, reset requests seen
  always @(posedge ref_clk) begin
    osc_tick <= ~osc_tick & ~rst;
    cyc <= cyc + 1;
    if (wdog_reset_req === 1'b1) n_req <= n_req + 1;
  end

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus phase; a slave that never answers ends the run
  task automatic wait_rdy;
    int n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test;
    end
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // wait for the status interrupt to go low, then high again
  task automatic irq_edge(output int t);
    int n = 0;
    while (rtc_irq !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    while (rtc_irq !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) begin
      fail_count++;
      stop_test;
    end
    t = cyc;
  endtask

  // cycles between two one-second events, cleared in between
  task second(input int exp);
    wr(32'h8, 32'h10);
    irq_edge(t1);
    wr(32'h8, 32'h10);
    irq_edge(t2);
    chk(t2 - t1, exp);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(32'h0, 32'h1);
    rd(32'h8, 32'h0);
    rd(32'h4, 32'h80);
    rd(32'hC, 32'h0);
    repeat (60) @(posedge ref_clk);
    chk(n_req, 32'h1);
    chk(wdog_irq, 32'h0);
    chk(hresp, 32'h0);
    rd(32'h0, 32'h201);
    rd(32'h8, 32'h10);
    $display("test 1 done");
    wr(32'h0, 32'h0);
    repeat (60) @(posedge ref_clk);
    rd(32'h0, 32'h0);
    chk(n_req, 32'h1);
    $display("test 2 done");
    wr(32'hC, 32'h80);
    wr(32'h0, 32'h3);
    repeat (60) @(posedge ref_clk);
    rd(32'h0, 32'h283);
    chk(wdog_irq, 32'h1);
    chk(rtc_irq, 32'h1);
    wr(32'h4, 32'h0);
    wr(32'h8, 32'h0);
    rd(32'h8, 32'h90);
    wr(32'h0, 32'h82);
    wr(32'h8, 32'hFF);
    rd(32'h0, 32'h2);
    rd(32'h8, 32'h0);
    chk(rtc_irq, 32'h0);
    chk(wdog_irq, 32'h0);
    repeat (40) @(posedge ref_clk);
    rd(32'h8, 32'h0);
    $display("test 3 done");
    wr(32'h4, 32'h80);
    wr(32'h8, 32'hFF);
    wr(32'hC, 32'h10);
    second(16);
    wr(32'h4, 32'hA0);
    rd(32'h4, 32'hA0);
    second(20);
    $display("test 4 done");
    stop_test;
  end
endmodule // tb_rwc_top
